//--- hw/cab_defines.vh
`ifndef CAB_DEFINES_VH
`define CAB_DEFINES_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CAB_OFS_CTRL 8'h00
`define CAB_OFS_OPA 8'h04
`define CAB_OFS_OPB 8'h08
`define CAB_OFS_ZPTR 8'h0C
`define CAB_OFS_FLAGS 8'h10
`define CAB_OFS_RESULT 8'h14
`define CAB_OFS_PC 8'h18
`define CAB_OFS_INFO 8'h1C

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CAB_CTRL_OP_HI 5
`define CAB_CTRL_BIT_LO 8
`define CAB_CTRL_BIT_HI 10
`define CAB_CTRL_TWO_WORD 12

// ----------------------------------------
// status flag positions
// ----------------------------------------
`define CAB_FLAG_C 0
`define CAB_FLAG_Z 1
`define CAB_FLAG_N 2
`define CAB_FLAG_V 3

// ----------------------------------------
// operation codes
// ----------------------------------------
`define CAB_OP_ADD 6'h00
`define CAB_OP_ADC 6'h01
`define CAB_OP_SUB 6'h02
`define CAB_OP_SBC 6'h03
`define CAB_OP_AND 6'h04
`define CAB_OP_OR 6'h05
`define CAB_OP_EOR 6'h06
`define CAB_OP_CBR 6'h07
`define CAB_OP_TST 6'h08
`define CAB_OP_MUL 6'h09
`define CAB_OP_PRODUCT_SIGNED 6'h0A
`define CAB_OP_PRODUCT_MIXED 6'h0B
`define CAB_OP_FRAC_PRODUCT_UNSIGNED 6'h0C
`define CAB_OP_FRAC_PRODUCT_SIGNED 6'h0D
`define CAB_OP_FRAC_PRODUCT_MIXED 6'h0E
`define CAB_OP_WADD 6'h0F
`define CAB_OP_WSUB 6'h10
`define CAB_OP_CP 6'h11
`define CAB_OP_CPC 6'h12
`define CAB_OP_CPI 6'h13
`define CAB_OP_SKEQ 6'h14
`define CAB_OP_SKRC 6'h15
`define CAB_OP_SKRS 6'h16
`define CAB_OP_SKPC 6'h17
`define CAB_OP_SKPS 6'h18
`define CAB_OP_BFS 6'h19
`define CAB_OP_BFC 6'h1A
`define CAB_OP_PJMP 6'h1B
`define CAB_OP_EPJMP 6'h1C
`define CAB_OP_BGE 6'h1D
`define CAB_OP_BLT 6'h1E

// ----------------------------------------
// cycle counts, limits, reset values
// ----------------------------------------
`define CAB_CYC_ONE 2'h1
`define CAB_CYC_TWO 2'h2
`define CAB_CYC_THREE 2'h3
`define CAB_IO_BIT_TOP 8'h1F
`define CAB_HAS_EXT_JUMP 1
`define CAB_RST_FLAGS 8'h00
`define CAB_RST_PC 22'h00_0000

`endif

//--- hw/cab_core.v
// The address map and the Wishbone slave port are this design's own decisions.
`include "cab_defines.vh"
`default_nettype none

// What this block does
// - add registers, optional carry, five flags
// - word add immediate, ZCNVS, two clocks
// - word subtract immediate, ZCNVS, two clocks
// - subtract register or constant, optional carry
// - and, or, xor set Z N V
// - clear bits: and with inverted constant
// - test: and register with itself
// - multiplies put product in high/low pair
// - fractional multiplies shift product left once
// - pointer jump loads pc from Z
// - extended jump uses extension above Z
// - skip next instruction when registers equal
// - compares set flags, write no register
// - skip on general register bit
// - skip on port register bit
// - branch on status flag chosen by index
// - signed branches use N xor V
// - branches on carry and negative flags
// - branches on interrupt enable flag
// - branches on H, T, V, Z, C
// - port skips only in low I/O range
// - extended jumps exist only in large variant
module cab_core #(
    parameter HAS_EXT_JUMP = `CAB_HAS_EXT_JUMP
) (
    input wire CORE_CLK,
    input wire ARST_N,
    input wire CLK_EN,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O
);

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    function [31:0] merge;
        input [31:0] old;
        input [31:0] upd;
        input [3:0] sel;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (sel[i])
                    merge[i*8 +: 8] = upd[i*8 +: 8];
        end
    endfunction

    function [7:0] arith_flags;
        input [7:0] f;
        input [7:0] d;
        input [7:0] r;
        input [7:0] s;
        input sub;
        input chain;
        reg h;
        reg v;
        reg c;
        reg z;
        begin
            if (sub)
            begin
                h = (~d[3] & r[3]) | (r[3] & s[3]) | (s[3] & ~d[3]);
                v = (d[7] & ~r[7] & ~s[7]) | (~d[7] & r[7] & s[7]);
                c = (~d[7] & r[7]) | (r[7] & s[7]) | (s[7] & ~d[7]);
            end
            else
            begin
                h = (d[3] & r[3]) | (r[3] & ~s[3]) | (~s[3] & d[3]);
                v = (d[7] & r[7] & ~s[7]) | (~d[7] & ~r[7] & s[7]);
                c = (d[7] & r[7]) | (r[7] & ~s[7]) | (~s[7] & d[7]);
            end
            // chained ops keep zero only if it was already set
            z = (s == 8'h00) & (~chain | f[`CAB_FLAG_Z]);
            // sign bit is not among the flags these ops touch
            arith_flags = {f[7:6], h, f[4], v, s[7], z, c};
        end
    endfunction

    function [7:0] logic_flags;
        input [7:0] f;
        input [7:0] s;
        begin
            logic_flags = {f[7:5], f[4], 1'b0, s[7], s == 8'h00, f[0]};
        end
    endfunction

    function [7:0] word_flags;
        input [7:0] f;
        input [7:0] dh;
        input [15:0] s;
        input sub;
        reg v;
        reg c;
        begin
            if (sub)
            begin
                v = dh[7] & ~s[15];
                c = s[15] & ~dh[7];
            end
            else
            begin
                v = ~dh[7] & s[15];
                c = ~s[15] & dh[7];
            end
            word_flags = {f[7:5], s[15] ^ v, v, s[15], s == 16'h0000, c};
        end
    endfunction

    function [7:0] mul_flags;
        input [7:0] f;
        input c;
        input [15:0] s;
        begin
            mul_flags = {f[7:2], s == 16'h0000, c};
        end
    endfunction

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg rst_meta_n;
    reg rst_n;

    always @(posedge CORE_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [12:0] ctrl;
    reg [15:0] opa;
    reg [7:0] opb;
    reg [15:0] zptr;
    reg [7:0] ext;
    reg [7:0] flags;
    reg [15:0] result;
    reg [21:0] pc;
    reg [1:0] busy_cnt;
    reg [1:0] last_cyc;
    reg err;

    wire bus_req = WB_CYC_I & WB_STB_I;
    // writes land on the edge where the master sees ack high
    wire bus_wr = bus_req & WB_WE_I & WB_ACK_O;
    wire start = bus_wr & (WB_ADR_I == `CAB_OFS_CTRL) & WB_SEL_I[0] &
        (busy_cnt == 2'h0);
    wire [31:0] ctrl_m = merge({19'h0_0000, ctrl}, WB_DAT_I, WB_SEL_I);
    wire [31:0] opa_m = merge({16'h0000, opa}, WB_DAT_I, WB_SEL_I);
    wire [31:0] opb_m = merge({24'h00_0000, opb}, WB_DAT_I, WB_SEL_I);
    wire [31:0] zptr_m = merge({8'h00, ext, zptr}, WB_DAT_I, WB_SEL_I);
    wire [31:0] pc_m = merge({10'h000, pc}, WB_DAT_I, WB_SEL_I);
    wire [12:0] ctrl_in = ctrl_m[12:0];

    // ----------------------------------------
    // operand paths
    // ----------------------------------------
    wire [5:0] op = ctrl_in[`CAB_CTRL_OP_HI:0];
    wire [2:0] bidx = ctrl_in[`CAB_CTRL_BIT_HI:`CAB_CTRL_BIT_LO];
    wire two_word = ctrl_in[`CAB_CTRL_TWO_WORD];
    wire [7:0] a = opa[7:0];
    wire [7:0] ah = opa[15:8];
    wire [7:0] b = opb;
    wire cin = flags[`CAB_FLAG_C];
    wire [7:0] add_res = a + b + {7'h00, op == `CAB_OP_ADC & cin};
    wire use_borrow = (op == `CAB_OP_SBC) | (op == `CAB_OP_CPC);
    wire [7:0] sub_res = a - b - {7'h00, use_borrow & cin};
    wire [15:0] wadd_res = opa + {10'h000, b[5:0]};
    wire [15:0] wsub_res = opa - {10'h000, b[5:0]};
    wire a_sign = (op == `CAB_OP_PRODUCT_SIGNED) | (op == `CAB_OP_PRODUCT_MIXED) |
        (op == `CAB_OP_FRAC_PRODUCT_SIGNED) | (op == `CAB_OP_FRAC_PRODUCT_MIXED);
    wire b_sign = (op == `CAB_OP_PRODUCT_SIGNED) | (op == `CAB_OP_FRAC_PRODUCT_SIGNED);
    wire [15:0] a_ext = {{8{a_sign & a[7]}}, a};
    wire [15:0] b_ext = {{8{b_sign & b[7]}}, b};
    wire [31:0] prod_full = a_ext * b_ext;
    wire [15:0] prod = prod_full[15:0];
    wire [21:0] seq_pc = pc + 22'h00_0001;
    // offset is a signed 7-bit word count
    wire [21:0] br_pc = pc + {{15{b[6]}}, b[6:0]} + 22'h00_0001;
    wire [21:0] skip_pc = pc + (two_word ? 22'h00_0003 : 22'h00_0002);
    wire [1:0] skip_cyc = two_word ? `CAB_CYC_THREE : `CAB_CYC_TWO;
    wire nv = flags[`CAB_FLAG_N] ^ flags[`CAB_FLAG_V];

    // ----------------------------------------
    // execute decode
    // ----------------------------------------
    reg [7:0] next_flags;
    reg [15:0] next_result;
    reg [21:0] next_pc;
    reg [1:0] next_cyc;
    reg next_err;
    reg skip_hit;
    reg br_hit;

    always @*
    begin
        next_flags = flags;
        next_result = result;
        next_pc = seq_pc;
        next_cyc = `CAB_CYC_ONE;
        next_err = 1'b0;
        skip_hit = 1'b0;
        br_hit = 1'b0;
        case (op)
            `CAB_OP_ADD, `CAB_OP_ADC:
            begin
                next_result = {8'h00, add_res};
                next_flags = arith_flags(flags, a, b, add_res, 1'b0, 1'b0);
            end
            `CAB_OP_SUB, `CAB_OP_SBC:
            begin
                next_result = {8'h00, sub_res};
                next_flags = arith_flags(flags, a, b, sub_res, 1'b1,
                    use_borrow);
            end
            `CAB_OP_CP, `CAB_OP_CPC, `CAB_OP_CPI:
                next_flags = arith_flags(flags, a, b, sub_res, 1'b1,
                    use_borrow);
            `CAB_OP_AND:
            begin
                next_result = {8'h00, a & b};
                next_flags = logic_flags(flags, a & b);
            end
            `CAB_OP_OR:
            begin
                next_result = {8'h00, a | b};
                next_flags = logic_flags(flags, a | b);
            end
            `CAB_OP_EOR:
            begin
                next_result = {8'h00, a ^ b};
                next_flags = logic_flags(flags, a ^ b);
            end
            `CAB_OP_CBR:
            begin
                next_result = {8'h00, a & (8'hFF - b)};
                next_flags = logic_flags(flags, a & (8'hFF - b));
            end
            `CAB_OP_TST:
            begin
                next_result = {8'h00, a & a};
                next_flags = logic_flags(flags, a & a);
            end
            `CAB_OP_MUL, `CAB_OP_PRODUCT_SIGNED, `CAB_OP_PRODUCT_MIXED:
            begin
                next_result = prod;
                next_flags = mul_flags(flags, prod[15], prod);
                next_cyc = `CAB_CYC_TWO;
            end
            `CAB_OP_FRAC_PRODUCT_UNSIGNED, `CAB_OP_FRAC_PRODUCT_SIGNED, `CAB_OP_FRAC_PRODUCT_MIXED:
            begin
                next_result = {prod[14:0], 1'b0};
                next_flags = mul_flags(flags, prod[15],
                    {prod[14:0], 1'b0});
                next_cyc = `CAB_CYC_TWO;
            end
            `CAB_OP_WADD:
            begin
                next_result = wadd_res;
                next_flags = word_flags(flags, ah, wadd_res, 1'b0);
                next_cyc = `CAB_CYC_TWO;
            end
            `CAB_OP_WSUB:
            begin
                next_result = wsub_res;
                next_flags = word_flags(flags, ah, wsub_res, 1'b1);
                next_cyc = `CAB_CYC_TWO;
            end
            `CAB_OP_SKEQ:
                skip_hit = a == b;
            `CAB_OP_SKRC:
                skip_hit = ~a[bidx];
            `CAB_OP_SKRS:
                skip_hit = a[bidx];
            `CAB_OP_SKPC, `CAB_OP_SKPS:
            begin
                if (b > `CAB_IO_BIT_TOP)
                    next_err = 1'b1;
                else
                    skip_hit = a[bidx] == (op == `CAB_OP_SKPS);
            end
            `CAB_OP_BFS:
                br_hit = flags[bidx];
            `CAB_OP_BFC:
                br_hit = ~flags[bidx];
            `CAB_OP_BGE:
                br_hit = ~nv;
            `CAB_OP_BLT:
                br_hit = nv;
            `CAB_OP_PJMP:
            begin
                next_pc = {6'h00, zptr};
                next_cyc = `CAB_CYC_TWO;
            end
            `CAB_OP_EPJMP:
            begin
                if (HAS_EXT_JUMP != 0)
                begin
                    next_pc = {ext[5:0], zptr};
                    next_cyc = `CAB_CYC_TWO;
                end
                else
                    next_err = 1'b1;
            end
            default:
                next_err = 1'b1;
        endcase
        if (skip_hit)
        begin
            next_pc = skip_pc;
            next_cyc = skip_cyc;
        end
        if (br_hit)
        begin
            next_pc = br_pc;
            next_cyc = `CAB_CYC_TWO;
        end
    end

    // ----------------------------------------
    // register file and execution
    // ----------------------------------------
    // results commit at the start edge; busy only models the clock count
    always @(posedge CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl <= 13'h0000;
            opa <= 16'h0000;
            opb <= 8'h00;
            zptr <= 16'h0000;
            ext <= 8'h00;
            flags <= `CAB_RST_FLAGS;
            result <= 16'h0000;
            pc <= `CAB_RST_PC;
            busy_cnt <= 2'h0;
            last_cyc <= 2'h0;
            err <= 1'b0;
        end
        else if (CLK_EN)
        begin
            if (busy_cnt != 2'h0)
                busy_cnt <= busy_cnt - 2'h1;
            if (start)
            begin
                ctrl <= ctrl_in;
                flags <= next_flags;
                result <= next_result;
                pc <= next_pc;
                busy_cnt <= next_cyc;
                last_cyc <= next_cyc;
                err <= next_err;
            end
            else if (bus_wr)
            begin
                case (WB_ADR_I)
                    `CAB_OFS_OPA:
                        opa <= opa_m[15:0];
                    `CAB_OFS_OPB:
                        opb <= opb_m[7:0];
                    `CAB_OFS_ZPTR:
                    begin
                        zptr <= zptr_m[15:0];
                        ext <= zptr_m[23:16];
                    end
                    `CAB_OFS_FLAGS:
                        if (WB_SEL_I[0])
                            flags <= WB_DAT_I[7:0];
                    `CAB_OFS_PC:
                        pc <= pc_m[21:0];
                    default:
                        err <= err;
                endcase
            end
        end
    end

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    // one wait state; unmapped reads answer zero, writes are dropped
    always @(posedge CORE_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end
        else if (CLK_EN)
        begin
            WB_ACK_O <= bus_req & ~WB_ACK_O;
            case (WB_ADR_I)
                `CAB_OFS_CTRL:
                    WB_DAT_O <= {19'h0_0000, ctrl};
                `CAB_OFS_OPA:
                    WB_DAT_O <= {16'h0000, opa};
                `CAB_OFS_OPB:
                    WB_DAT_O <= {24'h00_0000, opb};
                `CAB_OFS_ZPTR:
                    WB_DAT_O <= {8'h00, ext, zptr};
                `CAB_OFS_FLAGS:
                    WB_DAT_O <= {24'h00_0000, flags};
                `CAB_OFS_RESULT:
                    WB_DAT_O <= {16'h0000, result};
                `CAB_OFS_PC:
                    WB_DAT_O <= {10'h000, pc};
                `CAB_OFS_INFO:
                    WB_DAT_O <= {27'h000_0000, HAS_EXT_JUMP != 0, last_cyc,
                        err, busy_cnt != 2'h0};
                default:
                    WB_DAT_O <= 32'h0000_0000;
            endcase
        end
    end

endmodule

`default_nettype wire

//--- tb/cab_core_asserts.sv
`default_nettype none
module cab_core_chk #(
    parameter HAS_EXT_JUMP = 1
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic CLK_EN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);

    // ----------------------------------------
    // bus request shapes
    // ----------------------------------------
    sequence take_s;
        WB_CYC_I && WB_STB_I && CLK_EN && !WB_ACK_O;
    endsequence

    sequence read_s(adr);
        take_s ##0 (!WB_WE_I && WB_ADR_I == adr);
    endsequence

    // ----------------------------------------
    // handshake and read-back
    // ----------------------------------------
    ack_follows_a: assert property (take_s |=> WB_ACK_O)
        else $error("request not acked after one wait state");
    ack_single_a: assert property (WB_ACK_O && CLK_EN |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    ack_cause_a: assert property
        ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without a request");
    idle_quiet_a: assert property
        (!WB_CYC_I && !WB_ACK_O |=> !WB_ACK_O)
        else $error("ack while bus idle");
    unmapped_zero_a: assert property (take_s ##0 (!WB_WE_I &&
        (WB_ADR_I[1:0] != 2'h0 || WB_ADR_I > 8'h1C)) |=> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    ext_present_a: assert property
        (read_s(8'h1C) |=> WB_DAT_O[4] == (HAS_EXT_JUMP != 0))
        else $error("extended jump presence bit wrong");
    info_narrow_a: assert property
        (read_s(8'h1C) |=> WB_DAT_O[31:5] == 27'h0)
        else $error("status upper bits not zero");
    flags_narrow_a: assert property
        (read_s(8'h10) |=> WB_DAT_O[31:8] == 24'h0)
        else $error("flag register upper bits not zero");
    pc_narrow_a: assert property
        (read_s(8'h18) |=> WB_DAT_O[31:22] == 10'h0)
        else $error("pc upper bits not zero");
    result_narrow_a: assert property
        (read_s(8'h14) |=> WB_DAT_O[31:16] == 16'h0)
        else $error("result wider than a product");
endmodule

bind cab_core cab_core_chk #(.HAS_EXT_JUMP(HAS_EXT_JUMP)) u_chk (
    .CORE_CLK(CORE_CLK),
    .ARST_N(ARST_N),
    .CLK_EN(CLK_EN),
    .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O)
);
`default_nettype wire

//--- tb/tb_cab_core.sv
`default_nettype none
module tb_cab_core;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [16:0] NR = 17'h1_0000;
    logic CORE_CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic CLK_EN = 1'b1;
    logic WB_CYC_I = 1'b0;
    logic WB_STB_I = 1'b0;
    logic WB_WE_I = 1'b0;
    logic [7:0] WB_ADR_I = 8'h0;
    logic [3:0] WB_SEL_I = 4'h0;
    logic [31:0] WB_DAT_I = 32'h0;
    wire [31:0] WB_DAT_O;
    wire WB_ACK_O;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] rd;

    always #5 CORE_CLK = ~CORE_CLK;

    cab_core #(.HAS_EXT_JUMP(1)) dut (
        .CORE_CLK(CORE_CLK),
        .ARST_N(ARST_N),
        .CLK_EN(CLK_EN),
        .WB_CYC_I(WB_CYC_I),
        .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I),
        .WB_ADR_I(WB_ADR_I),
        .WB_SEL_I(WB_SEL_I),
        .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O),
        .WB_ACK_O(WB_ACK_O)
    );

    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // a hang anywhere ends here instead of running forever
    always @(posedge CORE_CLK)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_count++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // wishbone classic cycles
    // ----------------------------------------
    task automatic xfer(input logic we, input logic [7:0] adr,
        input logic [31:0] dat, input logic [3:0] sel,
        output logic [31:0] q);
        @(posedge CORE_CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= adr;
        WB_DAT_I <= dat;
        WB_SEL_I <= sel;
        do @(posedge CORE_CLK); while (WB_ACK_O !== 1'b1);
        q = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] q;
        xfer(1'b1, adr, dat, 4'hF, q);
    endtask

    task automatic rdr(input logic [7:0] adr, output logic [31:0] q);
        xfer(1'b0, adr, 32'h0, 4'hF, q);
    endtask

    // ----------------------------------------
    // one operation from pc 0x10, then read back
    // ----------------------------------------
    task automatic op(input logic [15:0] c, input logic [15:0] a,
        input logic [7:0] b, input logic [7:0] f, input logic [16:0] res,
        input logic [7:0] fl, input logic [21:0] pc, input logic [1:0] clk);
        logic [31:0] q;
        logic e;
        e = (c[5:0] > 6'h1E) ||
            ((c[5:0] == 6'h17 || c[5:0] == 6'h18) && b > 8'h1F);
        wr(8'h04, {16'h0, a});
        wr(8'h08, {24'h0, b});
        wr(8'h10, {24'h0, f});
        wr(8'h18, 32'h10);
        wr(8'h00, {16'h0, c});
        do rdr(8'h1C, q); while (q[0] !== 1'b0);
        check("err", {31'h0, q[1]}, {31'h0, e});
        if (clk != 2'h0)
            check("clocks", {30'h0, q[3:2]}, {30'h0, clk});
        if (!res[16])
        begin
            rdr(8'h14, q);
            check("result", q, {16'h0, res[15:0]});
        end
        rdr(8'h10, q);
        check("flags", q, {24'h0, fl});
        rdr(8'h18, q);
        check("pc", q, {10'h0, pc});
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (5) @(posedge CORE_CLK);
        ARST_N <= 1'b1;
        repeat (3) @(posedge CORE_CLK);
        rdr(8'h10, rd);
        check("flags reset", rd, 32'h0);
        rdr(8'h18, rd);
        check("pc reset", rd, 32'h0);
        rdr(8'h1C, rd);
        check("info reset", rd, 32'h10);
        rdr(8'h20, rd);
        check("unmapped", rd, 32'h0);
        wr(8'h0C, 32'h002A_1234);
        op(16'h0, 16'h8, 8'h8, 8'h0, 17'h10, 8'h20, 22'h11, 2'h1);
        op(16'h1, 16'hFF, 8'h0, 8'h1, 17'h0, 8'h23, 22'h11, 2'h1);
        op(16'h2, 16'h80, 8'h1, 8'h0, 17'h7F, 8'h28, 22'h11, 2'h1);
        op(16'h3, 16'h10, 8'hF, 8'h3, 17'h0, 8'h22, 22'h11, 2'h1);
        op(16'h4, 16'hF0, 8'h8F, 8'hFF, 17'h80, 8'hF5, 22'h11, 2'h1);
        op(16'h5, 16'h0, 8'h0, 8'h0, 17'h0, 8'h2, 22'h11, 2'h1);
        op(16'h6, 16'h5A, 8'h5A, 8'h8, 17'h0, 8'h2, 22'h11, 2'h1);
        op(16'h7, 16'hFF, 8'hF, 8'h0, 17'hF0, 8'h4, 22'h11, 2'h1);
        op(16'h8, 16'h0, 8'h55, 8'h4, 17'h0, 8'h2, 22'h11, 2'h1);
        op(16'h9, 16'hFF, 8'hFF, 8'h0, 17'hFE01, 8'h1, 22'h11, 2'h2);
        op(16'hA, 16'hFF, 8'h2, 8'h0, 17'hFFFE, 8'h1, 22'h11, 2'h2);
        op(16'hB, 16'hFF, 8'hFF, 8'h0, 17'hFF01, 8'h1, 22'h11, 2'h2);
        op(16'hC, 16'h80, 8'h80, 8'h1, 17'h8000, 8'h0, 22'h11, 2'h2);
        op(16'hD, 16'hC0, 8'h40, 8'h0, 17'hE000, 8'h1, 22'h11, 2'h2);
        op(16'hE, 16'h0, 8'h55, 8'h0, 17'h0, 8'h2, 22'h11, 2'h2);
        op(16'hF, 16'hFFFF, 8'h1, 8'h0, 17'h0, 8'h3, 22'h11, 2'h2);
        op(16'h10, 16'h0, 8'h3F, 8'h0, 17'hFFC1, 8'h15, 22'h11, 2'h2);
        op(16'h11, 16'h5, 8'h6, 8'h0, NR, 8'h25, 22'h11, 2'h1);
        op(16'h12, 16'h5, 8'h5, 8'h1, NR, 8'h25, 22'h11, 2'h1);
        op(16'h13, 16'h40, 8'h40, 8'h0, NR, 8'h2, 22'h11, 2'h1);
        op(16'h1014, 16'h33, 8'h33, 8'hA5, NR, 8'hA5, 22'h13, 2'h3);
        op(16'h14, 16'h33, 8'h34, 8'hA5, NR, 8'hA5, 22'h11, 2'h1);
        op(16'h315, 16'hF7, 8'h0, 8'h0, NR, 8'h0, 22'h12, 2'h2);
        op(16'h716, 16'h7F, 8'h0, 8'h0, NR, 8'h0, 22'h11, 2'h1);
        op(16'h17, 16'h0, 8'h1F, 8'h0, NR, 8'h0, 22'h12, 2'h2);
        op(16'h1018, 16'h1, 8'h1F, 8'h0, NR, 8'h0, 22'h13, 2'h3);
        op(16'h18, 16'h1, 8'h20, 8'h0, NR, 8'h0, 22'h11, 2'h1);
        op(16'h1B, 16'h0, 8'h0, 8'h0, NR, 8'h0, 22'h1234, 2'h2);
        op(16'h1C, 16'h0, 8'h0, 8'h0, NR, 8'h0, 22'h2A_1234, 2'h2);
        op(16'h1D, 16'h0, 8'h3, 8'hC, NR, 8'hC, 22'h14, 2'h2);
        op(16'h1E, 16'h0, 8'h70, 8'h4, NR, 8'h4, 22'h1, 2'h2);
        op(16'h1E, 16'h0, 8'h70, 8'hC, NR, 8'hC, 22'h11, 2'h1);
        op(16'h61A, 16'h0, 8'h7E, 8'h0, NR, 8'h0, 22'hF, 2'h2);
        // every flag index set: branch-if-set taken, branch-if-clear untaken
        for (int i = 0; i < 8; i++)
        begin
            op({5'h0, i[2:0], 8'h19}, 16'h0, 8'h5, 8'h1 << i, NR,
                8'h1 << i, 22'h16, 2'h2);
            op({5'h0, i[2:0], 8'h1A}, 16'h0, 8'h5, 8'h1 << i, NR,
                8'h1 << i, 22'h11, 2'h1);
        end
        op(16'h3F, 16'h0, 8'h0, 8'h0, NR, 8'h0, 22'h11, 2'h1);
        // low lane off: the jump must not start
        xfer(1'b1, 8'h00, 32'h1B, 4'hE, rd);
        rdr(8'h18, rd);
        check("pc kept", rd, 32'h11);
        // three-clock skip, then a jump written while still busy
        wr(8'h00, 32'h1014);
        wr(8'h00, 32'h1B);
        rdr(8'h18, rd);
        check("busy refused", rd, 32'h14);
        wrap_up();
    end
endmodule
`default_nettype wire
